// ---- verilog/timer_ctrl_pkg.sv ----
// Constants and carriers for the timer control
package timer_ctrl_pkg;

    localparam int NUM_CH = 5;
    localparam int CNT_W = 16;
    localparam int EXT_W = 4;
    localparam int CH_W = 3;
    localparam int ADDR_W = CH_W + 1;
    localparam int DIV_W = 3;

    // Special channels
    localparam int PHASE_CH = 2;
    localparam int PWM_CH_FIRST = 3;

    // Register byte layout
    localparam logic [7:0] COUNTER_CTRL_RESET = 8'h80;
    localparam logic [7:0] PIN_CTRL_RESET = 8'h88;
    localparam logic [7:0] COUNTER_CTRL_RSVD = 8'h80;
    localparam logic [7:0] PIN_CTRL_RSVD = 8'h88;
    localparam int CC_FIELD_HI = 6;
    localparam int CC_FIELD_LO = 0;
    localparam int FN_B_HI = 6;
    localparam int FN_B_LO = 4;
    localparam int FN_A_HI = 2;
    localparam int FN_A_LO = 0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Register select bit within the byte address, and GR_SEL value for the first general register
    localparam logic REG_SEL_COUNTER = 1'b0;
    localparam logic REG_SEL_PIN = 1'b1;
    localparam logic GR_SEL_FIRST = 1'b0;

    // Counter clear sources
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_ON_A = 2'h1;
    localparam logic [1:0] CLR_ON_B = 2'h2;
    localparam logic [1:0] CLR_SYNC = 2'h3;

    // Edge encoding shared by clock edge and capture edge fields
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;

    // General register function codes; the top bit means capture
    localparam logic [2:0] FN_NONE = 3'h0;
    localparam logic [2:0] FN_DRIVE0 = 3'h1;
    localparam logic [2:0] FN_DRIVE1 = 3'h2;
    localparam logic [2:0] FN_TOGGLE = 3'h3;
    localparam int FN_CAPTURE_BIT = 2;

    localparam int PRE_EXT_BIT = 2;
    localparam logic [DIV_W-1:0] DIV_RESET = 3'h0;
    localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] GR_RESET = 16'hffff;

    typedef struct packed {
        logic [1:0] clear_sel;
        logic [1:0] edge_sel;
        logic [2:0] prescale;
    } counter_ctrl_s;

    typedef struct packed {
        logic [2:0] fn_b;
        logic [2:0] fn_a;
    } pin_ctrl_s;

    typedef struct packed {
        logic rise;
        logic fall;
    } edge_s;

    function automatic logic edge_hit(logic [1:0] sel, edge_s e);
        if (sel[1]) begin
            return e.rise | e.fall;
        end else if (sel == EDGE_FALL) begin
            return e.fall;
        end
        return e.rise;
    endfunction

    function automatic logic [7:0] counter_ctrl_byte(counter_ctrl_s c);
        return COUNTER_CTRL_RSVD | {1'b0, c};
    endfunction

    function automatic logic [7:0] pin_ctrl_byte(pin_ctrl_s p);
        return PIN_CTRL_RSVD | {1'b0, p.fn_b, 1'b0, p.fn_a};
    endfunction

endpackage

// ---- verilog/timer_channel_unit.sv ----
// One timer channel: counter, two general registers, flags and pin drivers
`timescale 1ns/1ps
`default_nettype none

module timer_channel_unit #(
    parameter int CNT_W = 16,
    parameter bit TOGGLE_OK = 1'b1
) (
    input wire logic clk,
    input wire logic init,
    input wire logic tick,
    input wire logic count_down,
    input wire logic [1:0] clear_sel,
    input wire logic sync_clear,
    input wire logic [1:0][2:0] fn,
    input wire logic [1:0] cap,
    input wire logic [1:0] gr_wr,
    input wire logic [CNT_W-1:0] gr_wdata,
    input wire logic [1:0] flag_clr,
    output logic [CNT_W-1:0] count,
    output logic [1:0][CNT_W-1:0] gr,
    output logic [1:0] flag,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    output logic own_clear
);

    logic [1:0] eq;
    logic [1:0] eq_d_r;
    logic [1:0] match;
    logic [1:0] event_hit;
    logic clear_now;

    // A match is the first cycle of equality, so a stalled counter
    // does not retoggle the pin every cycle
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            eq[k] = !fn[k][timer_ctrl_pkg::FN_CAPTURE_BIT] &&
                (count == gr[k]);
            match[k] = eq[k] && !eq_d_r[k];
            event_hit[k] = match[k] | cap[k];
        end
        own_clear = ((clear_sel == timer_ctrl_pkg::CLR_ON_A) &&
            event_hit[0]) || ((clear_sel == timer_ctrl_pkg::CLR_ON_B) &&
            event_hit[1]);
        clear_now = own_clear ||
            ((clear_sel == timer_ctrl_pkg::CLR_SYNC) && sync_clear);
    end

    always_ff @(posedge clk) begin
        if (init) begin
            eq_d_r <= '0;
        end else begin
            eq_d_r <= eq;
        end
    end

    always_ff @(posedge clk) begin
        if (init) begin
            count <= timer_ctrl_pkg::COUNT_RESET;
        end else if (clear_now) begin
            count <= timer_ctrl_pkg::COUNT_RESET;
        end else if (tick && count_down) begin
            count <= count - CNT_W'(1);
        end else if (tick) begin
            count <= count + CNT_W'(1);
        end
    end

    // Capture beats a same-cycle write
    always_ff @(posedge clk) begin
        for (int k = 0; k < 2; k++) begin
            if (init) begin
                gr[k] <= CNT_W'(timer_ctrl_pkg::GR_RESET);
            end else if (cap[k]) begin
                gr[k] <= count;
            end else if (gr_wr[k]) begin
                gr[k] <= gr_wdata;
            end
        end
    end

    // Set beats clear when both arrive together
    always_ff @(posedge clk) begin
        if (init) begin
            flag <= '0;
        end else begin
            flag <= (flag & ~flag_clr) | event_hit;
        end
    end

    always_ff @(posedge clk) begin
        for (int k = 0; k < 2; k++) begin
            if (init) begin
                pin_out[k] <= 1'b0;
                pin_oe[k] <= 1'b0;
            end else begin
                pin_oe[k] <= !fn[k][timer_ctrl_pkg::FN_CAPTURE_BIT] &&
                    (fn[k] != timer_ctrl_pkg::FN_NONE);
                if (match[k]) begin
                    case (fn[k])
                        timer_ctrl_pkg::FN_DRIVE0: pin_out[k] <= 1'b0;
                        timer_ctrl_pkg::FN_DRIVE1: pin_out[k] <= 1'b1;
                        timer_ctrl_pkg::FN_TOGGLE: begin
                            pin_out[k] <= TOGGLE_OK ? !pin_out[k]
                                : 1'b1;
                        end
                        default: pin_out[k] <= pin_out[k];
                    endcase
                end
            end
        end
    end

endmodule // timer_channel_unit

`default_nettype wire

// ---- verilog/timer_channel_control.sv ----
// Five-channel timer control registers and routing
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Five channels, two read-write byte control registers
// - Counter control resets to 0x80 on reset/standby
// - Reserved bits ignore writes, read as one
// - Clear field picks none, A, B, sync
// - Clear event is match or capture, per function
// - Sync clear follows other synchronized channels
// - Edge field: rising, falling, or both edges
// - Prescale picks clock/1,2,4,8 or external A-D
// - Internal counts falling edges; external per edge field
// - Channel 2 phase counting overrides clock fields
// - Pin control resets to 0x88 on reset/standby
// - Field B: compare output actions or capture edges
// - Field A: same encoding for register A
// - Compare pin stays 0 until first match
// - Channel 2 toggle setting drives 1 instead
// - Channels 3,4 pin settings ignored in PWM
// - Compare match sets the matching flag
// - Capture latches counter and sets flag together
module timer_channel_control #(
    parameter int NUM_CH = timer_ctrl_pkg::NUM_CH,
    parameter int CNT_W = timer_ctrl_pkg::CNT_W
) (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic STANDBY,
    input wire logic [timer_ctrl_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic GR_WR,
    input wire logic [timer_ctrl_pkg::CH_W-1:0] GR_CH,
    input wire logic GR_SEL,
    input wire logic [CNT_W-1:0] GR_WDATA,
    input wire logic [NUM_CH-1:0] FLAG_CLR_A,
    input wire logic [NUM_CH-1:0] FLAG_CLR_B,
    input wire logic [NUM_CH-1:0] SYNC_SELECT,
    input wire logic PHASE_COUNT_MODE,
    input wire logic PHASE_STEP,
    input wire logic PHASE_DOWN,
    input wire logic PWM_PAIR_MODE,
    input wire logic [timer_ctrl_pkg::EXT_W-1:0] EXT_CLOCK_IN,
    input wire logic [NUM_CH-1:0] CHANNEL_PIN_A_IN,
    input wire logic [NUM_CH-1:0] CHANNEL_PIN_B_IN,
    output logic [NUM_CH-1:0] CHANNEL_PIN_A_OUT,
    output logic [NUM_CH-1:0] CHANNEL_PIN_A_OE,
    output logic [NUM_CH-1:0] CHANNEL_PIN_B_OUT,
    output logic [NUM_CH-1:0] CHANNEL_PIN_B_OE,
    output logic [NUM_CH-1:0][CNT_W-1:0] TIMER_COUNT,
    output logic [NUM_CH-1:0][CNT_W-1:0] GENERAL_REGISTER_FIRST,
    output logic [NUM_CH-1:0][CNT_W-1:0] GENERAL_REGISTER_SECOND,
    output logic [NUM_CH-1:0] EVENT_FLAG_A,
    output logic [NUM_CH-1:0] EVENT_FLAG_B
);

    localparam int EXT_W = timer_ctrl_pkg::EXT_W;
    localparam int CH_W = timer_ctrl_pkg::CH_W;
    localparam int DIV_W = timer_ctrl_pkg::DIV_W;
    localparam int PIN_W = 2 * NUM_CH;

    // Standby acts as reset
    logic init;
    assign init = SRST | STANDBY;

    timer_ctrl_pkg::counter_ctrl_s cc_r [NUM_CH];
    timer_ctrl_pkg::pin_ctrl_s pc_r [NUM_CH];

    logic [CH_W-1:0] reg_ch;
    logic reg_sel;
    logic reg_hit;
    assign reg_ch = REG_ADDR[timer_ctrl_pkg::ADDR_W-1:1];
    assign reg_sel = REG_ADDR[0];
    assign reg_hit = reg_ch < CH_W'(NUM_CH);

    // Register file: only the defined fields are stored, so writes to
    // reserved bits have nowhere to land
    always_ff @(posedge CORE_CLK) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (init) begin
                cc_r[c] <= timer_ctrl_pkg::counter_ctrl_s'(
                    timer_ctrl_pkg::COUNTER_CTRL_RESET[
                    timer_ctrl_pkg::CC_FIELD_HI:
                    timer_ctrl_pkg::CC_FIELD_LO]);
                pc_r[c] <= {timer_ctrl_pkg::PIN_CTRL_RESET[
                    timer_ctrl_pkg::FN_B_HI:timer_ctrl_pkg::FN_B_LO],
                    timer_ctrl_pkg::PIN_CTRL_RESET[
                    timer_ctrl_pkg::FN_A_HI:timer_ctrl_pkg::FN_A_LO]};
            end else if (REG_WR && reg_hit && (reg_ch == CH_W'(c))) begin
                if (reg_sel == timer_ctrl_pkg::REG_SEL_COUNTER) begin
                    cc_r[c] <= timer_ctrl_pkg::counter_ctrl_s'(
                        REG_WDATA[timer_ctrl_pkg::CC_FIELD_HI:
                        timer_ctrl_pkg::CC_FIELD_LO]);
                end else begin
                    pc_r[c] <= {REG_WDATA[timer_ctrl_pkg::FN_B_HI:
                        timer_ctrl_pkg::FN_B_LO],
                        REG_WDATA[timer_ctrl_pkg::FN_A_HI:
                        timer_ctrl_pkg::FN_A_LO]};
                end
            end
        end
    end

    // Read data follows last cycle's address
    always_ff @(posedge CORE_CLK) begin
        if (init) begin
            REG_RDATA <= timer_ctrl_pkg::UNMAPPED_READ;
        end else if (!reg_hit) begin
            REG_RDATA <= timer_ctrl_pkg::UNMAPPED_READ;
        end else if (reg_sel == timer_ctrl_pkg::REG_SEL_COUNTER) begin
            REG_RDATA <= timer_ctrl_pkg::counter_ctrl_byte(
                cc_r[reg_ch]);
        end else begin
            REG_RDATA <= timer_ctrl_pkg::pin_ctrl_byte(
                pc_r[reg_ch]);
        end
    end

    // Internal prescaler: a tick on the cycle the divided clock falls
    logic [DIV_W-1:0] div_r;
    logic [EXT_W-1:0] int_tick;

    always_ff @(posedge CORE_CLK) begin
        if (init) begin
            div_r <= timer_ctrl_pkg::DIV_RESET;
        end else begin
            div_r <= div_r + DIV_W'(1);
        end
    end

    always_comb begin
        int_tick[0] = 1'b1;
        for (int d = 1; d < EXT_W; d++) begin
            int_tick[d] = (div_r & DIV_W'((1 << d) - 1)) ==
                DIV_W'((1 << d) - 1);
        end
    end

    // Two sync flops, then a third for edge detection
    logic [EXT_W-1:0] ext_s1_r;
    logic [EXT_W-1:0] ext_s2_r;
    logic [EXT_W-1:0] ext_s3_r;
    logic [PIN_W-1:0] pin_s1_r;
    logic [PIN_W-1:0] pin_s2_r;
    logic [PIN_W-1:0] pin_s3_r;

    always_ff @(posedge CORE_CLK) begin
        if (init) begin
            ext_s1_r <= '0;
            ext_s2_r <= '0;
            ext_s3_r <= '0;
        end else begin
            ext_s1_r <= EXT_CLOCK_IN;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (init) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
        end else begin
            pin_s1_r <= {CHANNEL_PIN_B_IN, CHANNEL_PIN_A_IN};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    timer_ctrl_pkg::edge_s ext_edge [EXT_W];
    timer_ctrl_pkg::edge_s pin_edge [PIN_W];

    always_comb begin
        for (int e = 0; e < EXT_W; e++) begin
            ext_edge[e].rise = ext_s2_r[e] && !ext_s3_r[e];
            ext_edge[e].fall = !ext_s2_r[e] && ext_s3_r[e];
        end
        for (int p = 0; p < PIN_W; p++) begin
            pin_edge[p].rise = pin_s2_r[p] && !pin_s3_r[p];
            pin_edge[p].fall = !pin_s2_r[p] && pin_s3_r[p];
        end
    end

    // A synchronized channel's own clear drags sync-clear ones
    logic [NUM_CH-1:0] own_clear;
    logic [NUM_CH-1:0] sync_src;
    logic sync_clear;

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            sync_src[c] = own_clear[c] && SYNC_SELECT[c];
        end
        sync_clear = |sync_src;
    end

    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_ch
            localparam bit IS_PHASE = (i == timer_ctrl_pkg::PHASE_CH);
            localparam bit IS_PWM = (i >= timer_ctrl_pkg::PWM_CH_FIRST);
            logic tick;
            logic count_down;
            logic src_ext;
            logic [1:0] src_idx;
            logic pin_ignored;
            logic [1:0][2:0] fn;
            logic [1:0] cap;
            logic [1:0] gr_wr;

            always_comb begin
                src_ext = cc_r[i].prescale[timer_ctrl_pkg::PRE_EXT_BIT];
                src_idx = cc_r[i].prescale[1:0];
                if (IS_PHASE && PHASE_COUNT_MODE) begin
                    tick = PHASE_STEP;
                    count_down = PHASE_DOWN;
                end else if (src_ext) begin
                    tick = timer_ctrl_pkg::edge_hit(cc_r[i].edge_sel,
                        ext_edge[src_idx]);
                    count_down = 1'b0;
                end else begin
                    tick = int_tick[src_idx];
                    count_down = 1'b0;
                end
            end

            always_comb begin
                pin_ignored = IS_PWM && PWM_PAIR_MODE;
                fn[0] = pin_ignored ? timer_ctrl_pkg::FN_NONE
                    : pc_r[i].fn_a;
                fn[1] = pin_ignored ? timer_ctrl_pkg::FN_NONE
                    : pc_r[i].fn_b;
                cap[0] = fn[0][timer_ctrl_pkg::FN_CAPTURE_BIT] &&
                    timer_ctrl_pkg::edge_hit(fn[0][1:0], pin_edge[i]);
                cap[1] = fn[1][timer_ctrl_pkg::FN_CAPTURE_BIT] &&
                    timer_ctrl_pkg::edge_hit(fn[1][1:0],
                    pin_edge[i + NUM_CH]);
                gr_wr[0] = GR_WR && (GR_CH == CH_W'(i)) &&
                    (GR_SEL == timer_ctrl_pkg::GR_SEL_FIRST);
                gr_wr[1] = GR_WR && (GR_CH == CH_W'(i)) &&
                    (GR_SEL != timer_ctrl_pkg::GR_SEL_FIRST);
            end

            timer_channel_unit #(
                .CNT_W(CNT_W),
                .TOGGLE_OK(!IS_PHASE)
            ) u_unit (
                .clk(CORE_CLK),
                .init(init),
                .tick(tick),
                .count_down(count_down),
                .clear_sel(cc_r[i].clear_sel),
                .sync_clear(sync_clear && SYNC_SELECT[i]),
                .fn(fn),
                .cap(cap),
                .gr_wr(gr_wr),
                .gr_wdata(GR_WDATA),
                .flag_clr({FLAG_CLR_B[i], FLAG_CLR_A[i]}),
                .count(TIMER_COUNT[i]),
                .gr({GENERAL_REGISTER_SECOND[i],
                    GENERAL_REGISTER_FIRST[i]}),
                .flag({EVENT_FLAG_B[i], EVENT_FLAG_A[i]}),
                .pin_out({CHANNEL_PIN_B_OUT[i], CHANNEL_PIN_A_OUT[i]}),
                .pin_oe({CHANNEL_PIN_B_OE[i], CHANNEL_PIN_A_OE[i]}),
                .own_clear(own_clear[i])
            );
        end
    endgenerate

endmodule // timer_channel_control

`default_nettype wire

// ---- verification/timer_channel_control_props.sv ----
// Port assertions for the timer control
`timescale 1ns/1ps
`default_nettype none

module timer_channel_control_props #(
    parameter int NUM_CH = 5,
    parameter int CNT_W = 16
) (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic STANDBY,
    input wire logic [timer_ctrl_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic GR_WR,
    input wire logic [NUM_CH-1:0] FLAG_CLR_A,
    input wire logic PHASE_COUNT_MODE,
    input wire logic PHASE_STEP,
    input wire logic PWM_PAIR_MODE,
    input wire logic [NUM_CH-1:0] CHANNEL_PIN_A_OUT,
    input wire logic [NUM_CH-1:0] CHANNEL_PIN_A_OE,
    input wire logic [NUM_CH-1:0] CHANNEL_PIN_B_OE,
    input wire logic [NUM_CH-1:0][CNT_W-1:0] TIMER_COUNT,
    input wire logic [NUM_CH-1:0][CNT_W-1:0] GENERAL_REGISTER_FIRST,
    input wire logic [NUM_CH-1:0] EVENT_FLAG_A
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);

    sequence s_cc_write;
        REG_WR && !REG_ADDR[0] && REG_ADDR[3:1] < 3'h5 && !STANDBY
            ##1 !REG_WR && !STANDBY && $stable(REG_ADDR);
    endsequence
    property p_cc_readback;
        s_cc_write |=> REG_RDATA == ($past(REG_WDATA, 2) | 8'h80);
    endproperty
    a_cc_readback: assert property (p_cc_readback)
        else $error("control readback wrong");

    property p_reserved_ones;
        !$past(SRST) && !$past(STANDBY) && $past(REG_ADDR[3:1]) < 3'h5
            |-> REG_RDATA[7] && (REG_RDATA[3] || !$past(REG_ADDR[0]));
    endproperty
    a_reserved_ones: assert property (p_reserved_ones)
        else $error("reserved bit read 0");

    property p_standby_init;
        STANDBY |=> TIMER_COUNT == '0 && EVENT_FLAG_A == '0
            && GENERAL_REGISTER_FIRST == '1 && CHANNEL_PIN_A_OE == '0;
    endproperty
    a_standby_init: assert property (p_standby_init)
        else $error("standby state wrong");

    property p_flag_sticky;
        !$past(STANDBY) |->
            ($past(EVENT_FLAG_A) & ~EVENT_FLAG_A & ~$past(FLAG_CLR_A)) == '0;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag dropped unasked");

    property p_pin_first_match;
        (CHANNEL_PIN_A_OUT & ~$past(CHANNEL_PIN_A_OUT) & ~EVENT_FLAG_A) == '0;
    endproperty
    a_pin_first_match: assert property (p_pin_first_match)
        else $error("pin rose without event");

    property p_pwm_pins_off;
        PWM_PAIR_MODE ##1 PWM_PAIR_MODE
            |-> (CHANNEL_PIN_A_OE[4:3] | CHANNEL_PIN_B_OE[4:3]) == 2'h0;
    endproperty
    a_pwm_pins_off: assert property (p_pwm_pins_off)
        else $error("pin driven in pwm");

    sequence s_phase_idle;
        PHASE_COUNT_MODE ##1 PHASE_COUNT_MODE && !PHASE_STEP && !STANDBY;
    endsequence
    property p_phase_hold;
        s_phase_idle |=> TIMER_COUNT[2] == $past(TIMER_COUNT[2])
            || TIMER_COUNT[2] == '0;
    endproperty
    a_phase_hold: assert property (p_phase_hold)
        else $error("counted without step");

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        property p_capture_latch;
            GENERAL_REGISTER_FIRST[i] != $past(GENERAL_REGISTER_FIRST[i])
                && !$past(GR_WR) && !$past(STANDBY) |-> EVENT_FLAG_A[i]
                && GENERAL_REGISTER_FIRST[i] == $past(TIMER_COUNT[i]);
        endproperty
        a_capture_latch: assert property (p_capture_latch)
            else $error("register A changed alone");
    end
endmodule // timer_channel_control_props

bind timer_channel_control timer_channel_control_props #(
    .NUM_CH(NUM_CH),
    .CNT_W(CNT_W)
) u_props (
    .CORE_CLK, .SRST, .STANDBY, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RDATA,
    .GR_WR, .FLAG_CLR_A, .PHASE_COUNT_MODE, .PHASE_STEP, .PWM_PAIR_MODE,
    .CHANNEL_PIN_A_OUT, .CHANNEL_PIN_A_OE, .CHANNEL_PIN_B_OE, .TIMER_COUNT,
    .GENERAL_REGISTER_FIRST, .EVENT_FLAG_A
);

`default_nettype wire

// ---- verification/ext_side_model.sv ----
// Far side: external clock bursts and the shared channel pin wires
`timescale 1ns/1ps
`default_nettype none

module ext_side_model #(
    parameter int HALF = 3
) (
    input wire logic clk,
    input wire logic run,
    input wire logic [1:0] line,
    input wire logic [4:0] pin_a_lvl,
    input wire logic [4:0] pin_b_lvl,
    input wire logic [4:0] pin_a_out,
    input wire logic [4:0] pin_a_oe,
    input wire logic [4:0] pin_b_out,
    input wire logic [4:0] pin_b_oe,
    output logic [3:0] ext_clk,
    output logic [4:0] pin_a_in,
    output logic [4:0] pin_b_in
);
    int phase_cnt = 0;
    // A driven pin reads back the block's own level on the wire
    assign pin_a_in = (pin_a_oe & pin_a_out) | (~pin_a_oe & pin_a_lvl);
    assign pin_b_in = (pin_b_oe & pin_b_out) | (~pin_b_oe & pin_b_lvl);
    // Clocks idle low between bursts
    always @(posedge clk) begin
        if (!run) begin
            phase_cnt <= 0;
            ext_clk <= 4'h0;
        end else if (phase_cnt == HALF - 1) begin
            phase_cnt <= 0;
            ext_clk[line] <= ~ext_clk[line];
        end else begin
            phase_cnt <= phase_cnt + 1;
        end
    end
endmodule // ext_side_model

`default_nettype wire

// ---- verification/tb_timer_channel_control.sv ----
// Bench for the timer control block
`timescale 1ns/1ps
`default_nettype none

module tb_timer_channel_control;
    logic core_clk = 1'b0, srst = 1'b1, standby = 1'b0, reg_wr = 1'b0;
    logic gr_wr = 1'b0, gr_sel = 1'b0, run = 1'b0, pwm_mode = 1'b0;
    logic phase_mode = 1'b0, phase_step = 1'b0, phase_down = 1'b0;
    logic [timer_ctrl_pkg::ADDR_W-1:0] reg_addr = '0;
    logic [timer_ctrl_pkg::CH_W-1:0] gr_ch = '0;
    logic [7:0] reg_wdata = '0, reg_rdata;
    logic [15:0] gr_wdata = '0, c0;
    logic [4:0] flag_clr_a = '0, sync_select = '0, pin_a_lvl = '0;
    logic [4:0] pin_a_in, pin_b_in, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
    logic [4:0] flag_a, flag_b;
    logic [4:0][15:0] cnt, general_register_first, general_register_second;
    logic [3:0] ext_clk;
    logic [1:0] line = '0;
    int errors = 0, compares = 0, seed = 29369, n;
    int cc_m [5];
    int pc_m [5];

    always #5 core_clk = ~core_clk;

    timer_channel_control DUT (
        .CORE_CLK(core_clk), .SRST(srst), .STANDBY(standby),
        .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .GR_WR(gr_wr), .GR_CH(gr_ch),
        .GR_SEL(gr_sel), .GR_WDATA(gr_wdata), .FLAG_CLR_A(flag_clr_a),
        .FLAG_CLR_B(5'h00), .SYNC_SELECT(sync_select),
        .PHASE_COUNT_MODE(phase_mode), .PHASE_STEP(phase_step),
        .PHASE_DOWN(phase_down), .PWM_PAIR_MODE(pwm_mode),
        .EXT_CLOCK_IN(ext_clk), .CHANNEL_PIN_A_IN(pin_a_in),
        .CHANNEL_PIN_B_IN(pin_b_in), .CHANNEL_PIN_A_OUT(pin_a_out),
        .CHANNEL_PIN_A_OE(pin_a_oe), .CHANNEL_PIN_B_OUT(pin_b_out),
        .CHANNEL_PIN_B_OE(pin_b_oe), .TIMER_COUNT(cnt),
        .GENERAL_REGISTER_FIRST(general_register_first), .GENERAL_REGISTER_SECOND(general_register_second),
        .EVENT_FLAG_A(flag_a), .EVENT_FLAG_B(flag_b)
    );

    ext_side_model u_far (
        .clk(core_clk), .run(run), .line(line), .pin_a_lvl(pin_a_lvl),
        .pin_b_lvl(5'h00), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
        .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .ext_clk(ext_clk),
        .pin_a_in(pin_a_in), .pin_b_in(pin_b_in)
    );

    task automatic test_done;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %h vs %h", $time, seen, exp);
        end
    endtask

    task automatic model_init;
        for (int k = 0; k < 5; k++) begin
            cc_m[k] = 'h80;
            pc_m[k] = 'h88;
        end
    endtask

    task automatic wr(input int a, input int d);
        @(negedge core_clk);
        reg_addr = a[3:0];
        reg_wdata = d[7:0];
        reg_wr = 1'b1;
        if (a[3:1] < 5 && a[0]) pc_m[a[3:1]] = d;
        if (a[3:1] < 5 && !a[0]) cc_m[a[3:1]] = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd_check(input int a);
        int exp;
        @(negedge core_clk);
        reg_addr = a[3:0];
        @(negedge core_clk);
        exp = a[3:1] > 4 ? 0 : a[0] ? pc_m[a[3:1]] | 'h88 : cc_m[a[3:1]] | 'h80;
        check(reg_rdata, exp[7:0]);
    endtask

    task automatic gw(input int ch, input logic sel, input logic [15:0] d);
        @(negedge core_clk);
        gr_wr = 1'b1;
        gr_ch = ch[2:0];
        gr_sel = sel;
        gr_wdata = d;
        @(negedge core_clk);
        gr_wr = 1'b0;
    endtask

    task automatic clr_a(input int ch);
        @(negedge core_clk);
        flag_clr_a[ch] = 1'b1;
        @(negedge core_clk);
        flag_clr_a = '0;
    endtask

    task automatic wait_a(input int ch, input int lim);
        n = 0;
        while (flag_a[ch] !== 1'b1 && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        if (flag_a[ch] !== 1'b1) begin
            errors++;
            test_done();
        end
    endtask

    initial begin
        model_init();
        repeat (8) @(negedge core_clk);
        srst = 1'b0;
        sync_select = 5'h03;
        gw(0, 1'b0, 16'h0100);
        gw(2, 1'b0, 16'h0100);
        gw(4, 1'b1, 16'h0100);
        wr(0, 'h20);
        wr(1, 'h03);
        wr(2, 'h60);
        wr(4, 'h20);
        wr(5, 'h03);
        wr(8, 'h40);
        check(pin_a_out[0], 1'b0);
        check(pin_a_oe[0], 1'b1);
        wait_a(0, 600);
        check(cnt[0], 16'h0000);
        check(cnt[1], 16'h0000);
        check(cnt[4], 16'h0000);
        check(flag_b[4], 1'b1);
        check(general_register_second[4], 16'h0100);
        check({pin_a_out[2], pin_a_out[0]}, 2'h3);
        clr_a(0);
        wait_a(0, 600);
        check(n[15:0], 16'd255);
        check({pin_a_out[2], pin_a_out[0]}, 2'h2);
        for (int a = 0; a < 16; a++) begin
            wr(a, $random(seed));
            rd_check(a);
        end
        @(negedge core_clk);
        standby = 1'b1;
        @(negedge core_clk);
        standby = 1'b0;
        model_init();
        for (int a = 0; a < 16; a++) rd_check(a);
        for (int p = 0; p < 4; p++) begin
            wr(0, p);
            repeat (4) @(negedge core_clk);
            c0 = cnt[0];
            repeat (64) @(negedge core_clk);
            check(cnt[0] - c0, 16'd64 >> p);
        end
        for (int s = 0; s < 4; s++) begin
            for (int e = 0; e < 3; e++) begin
                wr(0, e * 8 + 4 + s);
                line = s[1:0];
                repeat (6) @(negedge core_clk);
                c0 = cnt[0];
                run = 1'b1;
                repeat (48) @(negedge core_clk);
                run = 1'b0;
                repeat (6) @(negedge core_clk);
                check(cnt[0] - c0, e == 2 ? 16'd16 : 16'd8);
            end
        end
        for (int j = 0; j < 4; j++) begin
            if (j == 3) wr(6, 'h20);
            wr(7, j == 3 ? 6 : 4 + j);
            clr_a(3);
            pin_a_lvl[3] = ~pin_a_lvl[3];
            wait_a(3, 10);
            if (j < 3) check(general_register_first[3], cnt[3] - 16'h1);
            else check(cnt[3], 16'h0000);
        end
        wr(7, 'h03);
        pwm_mode = 1'b1;
        repeat (2) @(negedge core_clk);
        check(pin_a_oe[3], 1'b0);
        pwm_mode = 1'b0;
        phase_mode = 1'b1;
        wr(4, $random(seed));
        c0 = cnt[2];
        for (int k = 0; k < 7; k++) begin
            phase_down = (k > 4);
            phase_step = 1'b1;
            @(negedge core_clk);
            phase_step = 1'b0;
            @(negedge core_clk);
        end
        check(cnt[2] - c0, 16'h0003);
        test_done();
    end
endmodule // tb_timer_channel_control

`default_nettype wire
